/* protector_pkg.sv */
// shared constants of the protector gate-control block
// assumes a 200 MHz reference clock; times converted to cycles or sample counts here
`default_nettype none
package protector_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned REF_CLK_HZ = 200_000_000;
  localparam int unsigned HOLDOFF_TIME_US = 5000;
  localparam int unsigned HOLDOFF_CYCLES =
    (HOLDOFF_TIME_US * (REF_CLK_HZ / 1_000_000));
  // override filter: full scale reached in about 10 ms of samples
  localparam int unsigned OVERRIDE_ENABLE_DEGLITCH_TIME_US = 7000;
  localparam int unsigned OVERRIDE_DISABLE_DEGLITCH_TIME_US = 7000;
  localparam int unsigned SAMPLE_PERIOD_US = 10;
  localparam int unsigned SAMPLE_CYCLES =
    (SAMPLE_PERIOD_US * (REF_CLK_HZ / 1_000_000));
  // counts to cross 70% from zero = 7 ms / sample period
  localparam int unsigned OVR_CROSS_COUNT =
    OVERRIDE_ENABLE_DEGLITCH_TIME_US / SAMPLE_PERIOD_US;
  localparam int unsigned OVR_ON_PCT = 70;
  localparam int unsigned OVR_OFF_PCT = 30;
  localparam int unsigned OVR_FULL = (OVR_CROSS_COUNT * 100) / OVR_ON_PCT;
  localparam int unsigned OVR_ON_LEVEL = (OVR_FULL * OVR_ON_PCT) / 100;
  localparam int unsigned OVR_OFF_LEVEL = (OVR_FULL * OVR_OFF_PCT) / 100;
  // cell-count pin deglitch
  localparam int unsigned CELL_COUNT_DEGLITCH_TIME_US = 1000;
  localparam int unsigned CELL_COUNT_SAMPLES =
    CELL_COUNT_DEGLITCH_TIME_US / SAMPLE_PERIOD_US;
  // ==========================================================
  // cell count codes
  typedef enum logic [1:0] {
    CELLS_3 = 2'h0,
    CELLS_4 = 2'h1,
    CELLS_5 = 2'h2
  } cell_count_e;
  localparam int unsigned MAX_CELLS = 5;
  localparam logic [4:0] CELL_MASK_3 = 5'h07;
  localparam logic [4:0] CELL_MASK_4 = 5'h0f;
  localparam logic [4:0] CELL_MASK_5 = 5'h1f;
  // three-level pin as two comparator bits
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h3;
endpackage : protector_pkg
`default_nettype wire

/* protector_fet_gate_control.sv */
// gate decision, override deglitch and cell-count decode of a pack protector
// assumes comparator and fault flags arrive asynchronously from analog logic
`default_nettype none
module protector_fet_gate_control #(
  parameter int unsigned HOLDOFF_CYCLES = protector_pkg::HOLDOFF_CYCLES,
  parameter int unsigned SAMPLE_CYCLES  = protector_pkg::SAMPLE_CYCLES,
  parameter int unsigned OVR_FULL       = protector_pkg::OVR_FULL,
  parameter int unsigned CELL_SAMPLES   = protector_pkg::CELL_COUNT_SAMPLES
) (
  input  wire logic       ref_clk,                   // 200 MHz clock
  input  wire logic       rst_b,                     // async reset, low
  input  wire logic [4:0] cell_uv_raw,               // per-cell undervoltage
  input  wire logic       cell_overvoltage_fault,    // any cell over
  input  wire logic       open_wire_fault,           // open wire
  input  wire logic       charge_overtemp_fault,     // otc
  input  wire logic       charge_undertemp_fault,    // utc
  input  wire logic       discharge_overtemp_fault,  // otd
  input  wire logic       discharge_undertemp_fault, // utd
  input  wire logic       overcurrent_stage1_fault,  // ocd stage 1
  input  wire logic       overcurrent_stage2_fault,  // ocd stage 2
  input  wire logic       short_circuit_fault,       // short circuit
  input  wire logic       state_charge_cmp,          // sense above chg thr
  input  wire logic       state_discharge_cmp,       // sense <= dsg thr
  input  wire logic       charge_override_in,        // high = enabled
  input  wire logic       discharge_override_in,     // high = enabled
  input  wire logic [1:0] cell_count_select,         // pin level code
  output logic            charge_gate_drive,         // charge fet gate
  output logic            discharge_gate_drive,      // discharge fet gate
  output logic            upper_charge_relay,        // copy for stack
  output logic            current_detect_enable,     // ocd/scd enable
  output logic            state_cmp_enable,          // comparator on
  output logic            state_cmp_charge_sel,      // 1: charge thr
  output logic [1:0]      cell_count,                // decoded count
  output logic            cell_undervoltage_fault,   // masked uv
  output logic            charge_gate_inhibit,       // charge fault sum
  output logic            discharge_gate_inhibit     // discharge fault sum
);
  // ==========================================================
  // parameter checks
  localparam int unsigned OVR_W = $clog2(OVR_FULL + 1);
  localparam int unsigned SMP_W = $clog2(SAMPLE_CYCLES + 1);
  localparam int unsigned HLD_W = $clog2(HOLDOFF_CYCLES + 1);
  localparam int unsigned CEL_W = $clog2(CELL_SAMPLES + 1);
  localparam logic [OVR_W-1:0] ON_LEVEL =
    OVR_W'((OVR_FULL * protector_pkg::OVR_ON_PCT) / 100);
  localparam logic [OVR_W-1:0] OFF_LEVEL =
    OVR_W'((OVR_FULL * protector_pkg::OVR_OFF_PCT) / 100);
  localparam logic [OVR_W-1:0] FULL = OVR_W'(OVR_FULL);
  localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(SAMPLE_CYCLES - 1);
  localparam logic [HLD_W-1:0] HLD_END = HLD_W'(HOLDOFF_CYCLES);
  localparam logic [CEL_W-1:0] CEL_END = CEL_W'(CELL_SAMPLES);
  // five uv flags, nine fault flags, two comparators, two overrides,
  // and the two-bit cell-count pin code
  localparam int unsigned NSYNC = 20;

  initial begin
    if (OVR_FULL < 4 || SAMPLE_CYCLES < 1 || HOLDOFF_CYCLES < 1 ||
        CELL_SAMPLES < 1) begin
      $error("protector_fet_gate_control: parameter out of range");
    end
  end

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_sync;
  // two stages so release never lands near a clock edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // input synchronisers
  wire logic [NSYNC-1:0] raw_in = {cell_count_select, charge_override_in,
    discharge_override_in, state_charge_cmp, state_discharge_cmp,
    short_circuit_fault, overcurrent_stage2_fault, overcurrent_stage1_fault,
    discharge_undertemp_fault, discharge_overtemp_fault,
    charge_undertemp_fault, charge_overtemp_fault, open_wire_fault,
    cell_overvoltage_fault, cell_uv_raw};
  logic [NSYNC-1:0] sync_meta;
  logic [NSYNC-1:0] sync_q;
  // analog flags are registered before any decision
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      sync_meta <= '0;
      sync_q    <= '0;
    end else begin
      sync_meta <= raw_in;
      sync_q    <= sync_meta;
    end
  end
  wire logic [4:0] s_uv   = sync_q[4:0];
  wire logic       s_ov   = sync_q[5];
  wire logic       s_ow   = sync_q[6];
  wire logic       s_otc  = sync_q[7];
  wire logic       s_utc  = sync_q[8];
  wire logic       s_otd  = sync_q[9];
  wire logic       s_utd  = sync_q[10];
  wire logic       s_oc1  = sync_q[11];
  wire logic       s_oc2  = sync_q[12];
  wire logic       s_scd  = sync_q[13];
  wire logic       s_sdc  = sync_q[14];
  wire logic       s_scc  = sync_q[15];
  wire logic       s_discharge_override_in = sync_q[16];
  wire logic       s_charge_override_in = sync_q[17];
  // cell-count pin code rides in the top two synchroniser bits
  wire logic [1:0] s_cell_count_select_pin = sync_q[NSYNC-1:NSYNC-2];

  // ==========================================================
  // sample tick and hold-off
  logic [SMP_W-1:0] smp_cnt;
  logic [HLD_W-1:0] hold_cnt;
  wire logic tick = (smp_cnt == SMP_LAST);
  wire logic hold_done = (hold_cnt == HLD_END);
  // hold-off keeps both gates off while the supply settles
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      smp_cnt  <= '0;
      hold_cnt <= '0;
    end else begin
      smp_cnt <= tick ? '0 : smp_cnt + 1'b1;
      if (!hold_done) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // override deglitch filters
  logic [OVR_W-1:0] cnt_c;
  logic [OVR_W-1:0] cnt_d;
  logic             ovr_c_en;
  logic             ovr_d_en;
  wire logic [OVR_W-1:0] next_cnt_c = s_charge_override_in ?
    ((cnt_c == FULL) ? cnt_c : cnt_c + 1'b1) :
    ((cnt_c == '0) ? cnt_c : cnt_c - 1'b1);
  wire logic [OVR_W-1:0] next_cnt_d = s_discharge_override_in ?
    ((cnt_d == FULL) ? cnt_d : cnt_d + 1'b1) :
    ((cnt_d == '0) ? cnt_d : cnt_d - 1'b1);
  // hysteresis between 30 and 70 percent rejects chatter; adds latency
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cnt_c    <= '0;
      cnt_d    <= '0;
      ovr_c_en <= 1'b0;
      ovr_d_en <= 1'b0;
    end else if (tick) begin
      cnt_c <= next_cnt_c;
      cnt_d <= next_cnt_d;
      if (next_cnt_c > ON_LEVEL) begin
        ovr_c_en <= 1'b1;
      end else if (next_cnt_c < OFF_LEVEL) begin
        ovr_c_en <= 1'b0;
      end
      if (next_cnt_d > ON_LEVEL) begin
        ovr_d_en <= 1'b1;
      end else if (next_cnt_d < OFF_LEVEL) begin
        ovr_d_en <= 1'b0;
      end
    end
  end

  // ==========================================================
  // cell count decode
  logic [1:0]       cell_count_select_last;
  logic [CEL_W-1:0] cell_count_select_stable;
  // decode from the last sampled level; code 2'h2 also means five cells
  wire logic [1:0] dec_count =
    (cell_count_select_last == protector_pkg::LEVEL_LOW)  ? protector_pkg::CELLS_3 :
    (cell_count_select_last == protector_pkg::LEVEL_MID)  ? protector_pkg::CELLS_4 :
    protector_pkg::CELLS_5;
  // pin re-checked every sample so a late strap change is followed
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cell_count_select_last   <= protector_pkg::LEVEL_LOW;
      cell_count_select_stable <= '0;
      cell_count  <= protector_pkg::CELLS_3;
    end else if (tick) begin
      cell_count_select_last <= s_cell_count_select_pin;
      if (s_cell_count_select_pin != cell_count_select_last) begin
        cell_count_select_stable <= '0;
      end else if (cell_count_select_stable != CEL_END) begin
        cell_count_select_stable <= cell_count_select_stable + 1'b1;
      end else begin
        cell_count <= dec_count;
      end
    end
  end
  // unused cell inputs are shorted, so their uv flags are masked out
  wire logic [4:0] cell_mask =
    (cell_count == protector_pkg::CELLS_3) ? protector_pkg::CELL_MASK_3 :
    (cell_count == protector_pkg::CELLS_4) ? protector_pkg::CELL_MASK_4 :
    protector_pkg::CELL_MASK_5;
  wire logic uv_any = |(s_uv & cell_mask);

  // ==========================================================
  // gate decision
  // hard faults are shared by both drivers
  wire logic hard_fault = s_ow | s_otd | s_utd | s_oc1 | s_oc2 | s_scd;
  wire logic dsg_off = uv_any | hard_fault | !ovr_d_en;
  wire logic chg_off = s_ov | s_otc | s_utc | hard_fault |
    !ovr_c_en;
  wire logic dsg_only = dsg_off & !chg_off;
  wire logic chg_only = chg_off & !dsg_off;
  // body-diode protection in the opposite current direction
  wire logic dsg_rescue = dsg_only & s_scc & ovr_d_en;
  wire logic chg_rescue = chg_only & s_sdc & ovr_c_en;
  wire logic next_dsg = hold_done & (!dsg_off | dsg_rescue);
  wire logic next_chg = hold_done & (!chg_off | chg_rescue);

  // registered gate drive; override latency stacks onto fault timing
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      discharge_gate_drive    <= 1'b0;
      charge_gate_drive       <= 1'b0;
      upper_charge_relay      <= 1'b0;
      current_detect_enable   <= 1'b0;
      state_cmp_enable        <= 1'b0;
      state_cmp_charge_sel    <= 1'b0;
      cell_undervoltage_fault <= 1'b0;
      charge_gate_inhibit     <= 1'b0;
      discharge_gate_inhibit  <= 1'b0;
    end else begin
      discharge_gate_drive    <= next_dsg;
      charge_gate_drive       <= next_chg;
      upper_charge_relay      <= next_chg;
      current_detect_enable   <= next_dsg;
      state_cmp_enable        <= hold_done & (dsg_only | chg_only);
      state_cmp_charge_sel    <= dsg_only;
      cell_undervoltage_fault <= uv_any;
      charge_gate_inhibit     <= chg_off;
      discharge_gate_inhibit  <= dsg_off;
    end
  end
endmodule : protector_fet_gate_control
`default_nettype wire

/* protector_gate_sva.sv */
// port checker for the pack protector gate control
// assumes it is bound into protector_fet_gate_control
`default_nettype none
module protector_gate_sva #(
  parameter int unsigned HOLDOFF_CYCLES = 20
) (
  input wire logic       ref_clk,                   // clock
  input wire logic       rst_b,                     // reset, low
  input wire logic [4:0] cell_uv_raw,               // raw uv flags
  input wire logic       open_wire_fault,           // hard fault
  input wire logic       discharge_overtemp_fault,  // hard fault
  input wire logic       discharge_undertemp_fault, // hard fault
  input wire logic       overcurrent_stage1_fault,  // hard fault
  input wire logic       overcurrent_stage2_fault,  // hard fault
  input wire logic       short_circuit_fault,       // hard fault
  input wire logic       charge_gate_drive,         // charge gate
  input wire logic       discharge_gate_drive,      // discharge gate
  input wire logic       upper_charge_relay,        // stack copy
  input wire logic       current_detect_enable,     // ocd/scd enable
  input wire logic       state_cmp_enable,          // comparator on
  input wire logic       state_cmp_charge_sel,      // charge threshold
  input wire logic [1:0] cell_count,                // decoded count
  input wire logic       cell_undervoltage_fault,   // masked uv
  input wire logic       charge_gate_inhibit,       // charge faults
  input wire logic       discharge_gate_inhibit     // discharge faults
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // helpers: cycles since release saturate at the hold-off span
  logic [31:0] since_rel;
  wire logic hard = open_wire_fault | discharge_overtemp_fault |
    discharge_undertemp_fault | overcurrent_stage1_fault |
    overcurrent_stage2_fault | short_circuit_fault;
  wire logic both_off = !charge_gate_drive && !discharge_gate_drive;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) since_rel <= 32'h0;
    else if (since_rel < HOLDOFF_CYCLES) since_rel <= since_rel + 32'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // assertions: four samples cover the two sync flops and output flop
  a_relay_mirror: assert property (
    upper_charge_relay == charge_gate_drive)
    else $error("relay output differs from charge gate");
  a_detect_follow: assert property (
    current_detect_enable == discharge_gate_drive)
    else $error("current detection not tied to discharge gate");
  a_hard_both_off: assert property (
    hard [*4] |-> both_off && !state_cmp_enable)
    else $error("hard fault left a gate or comparator on");
  a_holdoff_off: assert property (
    since_rel < HOLDOFF_CYCLES |-> both_off)
    else $error("gate on during hold-off");
  a_cmp_not_both: assert property (
    charge_gate_inhibit && discharge_gate_inhibit |-> !state_cmp_enable)
    else $error("comparator on with both gates inhibited");
  a_cmp_thresh_sel: assert property (
    state_cmp_enable && discharge_gate_inhibit && !charge_gate_inhibit
    |-> state_cmp_charge_sel)
    else $error("wrong comparator threshold");
  a_dsg_rescue: assert property (
    discharge_gate_drive && discharge_gate_inhibit
    |-> state_cmp_enable && state_cmp_charge_sel)
    else $error("discharge gate on under fault without rescue");
  a_chg_rescue: assert property (
    charge_gate_drive && charge_gate_inhibit
    |-> state_cmp_enable && !state_cmp_charge_sel)
    else $error("charge gate on under fault without rescue");
  a_count_legal: assert property (
    cell_count != 2'h3)
    else $error("illegal cell count code");
  a_uv_masked: assert property (
    (cell_count == 2'h0 && cell_uv_raw[2:0] == 3'h0) [*4]
    |-> !cell_undervoltage_fault)
    else $error("uv from an unused cell input");
  // main scenarios reached
  c_hard: cover property (hard [*4]);
  c_dsg_rescue: cover property (discharge_gate_drive && discharge_gate_inhibit);
  c_chg_rescue: cover property (charge_gate_drive && charge_gate_inhibit);
  c_five_cells: cover property (cell_count == 2'h2);
endmodule : protector_gate_sva
bind protector_fet_gate_control protector_gate_sva
  #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) chk (.*);
`default_nettype wire

/* protector_far_side.sv */
// far side: sense resistor feeding the state comparator, upper stack device
// assumes the bench sets pack current and the upper device gate states
`default_nettype none
module protector_far_side #(
  parameter int STATE_C_MV = 2,  // charge-state threshold, plain default
  parameter int STATE_D_MV = -2  // discharge-state threshold, plain default
) (
  input  var int    sense_mv,              // sense_pos minus sense_neg
  input  wire logic upper_chg,             // upper device relay output
  input  wire logic upper_dsg,             // upper device discharge gate
  output logic      state_charge_cmp,      // charging sensed
  output logic      state_discharge_cmp,   // discharging sensed
  output logic      charge_override_in,    // override, high enabled
  output logic      discharge_override_in  // override, high enabled
);
  timeunit 1ns;
  timeprecision 100ps;
  // comparator levels: thresholds never overlap, so never both high
  assign state_charge_cmp = (sense_mv > STATE_C_MV);
  assign state_discharge_cmp = (sense_mv <= STATE_D_MV);
  // stacked wiring: upper outputs land on the lower override pins
  assign charge_override_in = upper_chg;
  assign discharge_override_in = upper_dsg;
endmodule : protector_far_side
`default_nettype wire

/* protector_fet_gate_control_test.sv */
// self-checking bench for the protector gate control
// assumes the far-side model and the bound checker are compiled first
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %b want %b", $time, a, b); end end
module protector_fet_gate_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_b, upper_chg, upper_dsg;
  logic [4:0] cell_uv_raw;
  logic [1:0] cell_count_select, exp_cnt, cell_count;
  logic [8:0] flt;
  logic [31:0] r;
  int seed, sense_mv, fails, tests_run;
  logic cell_overvoltage_fault, open_wire_fault, charge_overtemp_fault;
  logic charge_undertemp_fault, discharge_overtemp_fault;
  logic discharge_undertemp_fault, overcurrent_stage1_fault;
  logic overcurrent_stage2_fault, short_circuit_fault;
  logic state_charge_cmp, state_discharge_cmp, charge_override_in;
  logic discharge_override_in, charge_gate_drive, discharge_gate_drive;
  logic upper_charge_relay, current_detect_enable, state_cmp_enable;
  logic state_cmp_charge_sel, cell_undervoltage_fault;
  logic charge_gate_inhibit, discharge_gate_inhibit;
  assign {short_circuit_fault, overcurrent_stage2_fault,
    overcurrent_stage1_fault, discharge_undertemp_fault,
    discharge_overtemp_fault, charge_undertemp_fault,
    charge_overtemp_fault, open_wire_fault, cell_overvoltage_fault} = flt;
  // short counts keep the run to a few hundred cycles
  protector_fet_gate_control #(.HOLDOFF_CYCLES(20), .SAMPLE_CYCLES(2),
    .OVR_FULL(10), .CELL_SAMPLES(3)) uut (.*);
  protector_far_side far (.*);
  // ==========================================================
  // expectations
  function automatic logic exp_gate(input logic own_f, oth_f, own_o,
      oth_o, rescue);
    return own_o && (!own_f || (oth_o && !oth_f && rescue));
  endfunction : exp_gate
  function automatic logic [1:0] decode(input logic [1:0] l);
    return (l == 2'h0) ? 2'h0 : (l == 2'h1) ? 2'h1 : 2'h2;
  endfunction : decode
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic check_gates();
    logic uv, cf, df, ec, ed;
    uv = |(cell_uv_raw & ((exp_cnt == 2'h0) ? 5'h07 :
      (exp_cnt == 2'h1) ? 5'h0f : 5'h1f));
    cf = |(flt & 9'h1ff);
    df = |(flt & 9'h1f2) | uv;
    ec = exp_gate(cf, df, upper_chg, upper_dsg, sense_mv <= -2);
    ed = exp_gate(df, cf, upper_dsg, upper_chg, sense_mv > 2);
    // inhibit sums include a disabled override
    cf = cf | !upper_chg;
    df = df | !upper_dsg;
    `CHK(cell_undervoltage_fault, uv)
    `CHK(charge_gate_drive, ec)
    `CHK(discharge_gate_drive, ed)
    `CHK(upper_charge_relay, ec)
    `CHK(current_detect_enable, ed)
    `CHK({charge_gate_inhibit, discharge_gate_inhibit}, {cf, df})
    `CHK(state_cmp_enable, cf ^ df)
    `CHK(state_cmp_charge_sel, df & !cf)
  endtask : check_gates
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // clock and watchdog, nearly six times the expected run
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    fails++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 99297;
    {rst_b, flt, cell_uv_raw, sense_mv, exp_cnt} = '0;
    {upper_chg, upper_dsg, cell_count_select} = 4'hc;
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    step(3);
    `CHK({charge_gate_drive, discharge_gate_drive, cell_count}, 4'h0)
    step(80);
    check_gates();
    // random faults, sense levels and uv on used and unused inputs
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      flt = r[4] ? 9'h0 : (9'h1 << (r[3:0] % 9));
      if (r[5]) flt[r[9:6] % 9] = 1'b1;
      cell_uv_raw = r[15] ? r[14:10] : 5'h0;
      sense_mv = int'($signed(r[19:16]));
      step(5);
      check_gates();
    end
    {flt, cell_uv_raw, sense_mv} = '0;
    // override glitch, then a long disable, then re-enable
    for (int k = 0; k < 2; k++) begin
      {upper_chg, upper_dsg} = k ? 2'b10 : 2'b01;
      step(2);
      {upper_chg, upper_dsg} = 2'b11;
      step(5);
      check_gates();
      {upper_chg, upper_dsg} = k ? 2'b10 : 2'b01;
      step(40);
      check_gates();
      {upper_chg, upper_dsg} = 2'b11;
      step(12);
      `CHK(k ? discharge_gate_drive : charge_gate_drive, 1'b0)
      step(28);
      check_gates();
    end
    // cell-count pin: short glitch ignored, steady level taken
    cell_uv_raw = 5'h18;
    for (int k = 0; k < 4; k++) begin
      r[1:0] = (k == 0) ? 2'h1 : (k == 1) ? 2'h3 : (k == 2) ? 2'h2 : 2'h0;
      cell_count_select = r[1:0];
      step(2);
      cell_count_select = (k == 0) ? 2'h0 : (k == 1) ? 2'h1 : 2'h3;
      step(10);
      `CHK(cell_count, exp_cnt)
      cell_count_select = r[1:0];
      exp_cnt = decode(r[1:0]);
      step(20);
      `CHK(cell_count, exp_cnt)
      check_gates();
    end
    test_done();
  end
endmodule : protector_fet_gate_control_test
`default_nettype wire
